/* ctb_pkg.sv */
// Summary of operation
// R1: Rx FIFO size codes map to payload bytes
// R2: Oversized receive payload truncated to element size
// R3: Shared group is FIFO or priority queue
// R4: FIFO/queue count, above 32 means 32
// R5: Dedicated buffer count, above 32 means 32
// R6: Section start is a word address
// R7: Dedicated buffers first, sum unchecked
// R8: FIFO/queue status derived from pending bits
// R9: Full flag and put index reported
// R10: Get index, zero in queue mode
// R11: Consecutive free level, zero in queue mode
// R12: Indices count from first dedicated buffer
// R13: Tx size codes map to payload bytes
// R14: Missing transmit bytes sent as padding
// R15: Pending bit per buffer, add sets it
// R16: New pending bit starts priority scan
// R17: Cancel clears pending, deferred while on bus
// R18: Cancel request cleared after pending clears
// R19: Cancellation finished set in listed cases
// R20: Retransmit disabled cancels failed sends
// R21: Late pending bits excluded from scan
// R22: Add to pending buffer ignored
// R23: Occurred set on success, cleared by add
// R24: Late additions trigger a fresh scan
package ctb_pkg;
    localparam logic [11:0] OFS_RX_ESC = 12'h0BC;
    localparam logic [11:0] OFS_TX_CFG = 12'h0C0;
    localparam logic [11:0] OFS_TX_STAT = 12'h0C4;
    localparam logic [11:0] OFS_TX_ESC = 12'h0C8;
    localparam logic [11:0] OFS_TX_PEND = 12'h0CC;
    localparam logic [11:0] OFS_CTRL = 12'h0F0;
    localparam int QSEL_POS = 30;
    localparam int FQS_LSB = 24;
    localparam int DED_LSB = 16;
    localparam int START_LSB = 2;
    localparam int FULL_POS = 21;
    localparam int PUT_LSB = 16;
    localparam int GET_LSB = 8;
    localparam int FREE_LSB = 0;
    localparam int RX0_SIZE_LSB = 0;
    localparam int RX1_SIZE_LSB = 4;
    localparam int RBDS_LSB = 8;
    localparam int TXDS_LSB = 0;
    localparam int RETX_OFF_POS = 0;
    localparam logic [5:0] MAX_BUF = 6'h20;
    localparam logic [7:0] PAD_BYTE = 8'hCC;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    function automatic logic [6:0] ctb_size_bytes(input logic [2:0] code);
        case (code)
            3'h0: ctb_size_bytes = 7'h08;
            3'h1: ctb_size_bytes = 7'h0C;
            3'h2: ctb_size_bytes = 7'h10;
            3'h3: ctb_size_bytes = 7'h14;
            3'h4: ctb_size_bytes = 7'h18;
            3'h5: ctb_size_bytes = 7'h20;
            3'h6: ctb_size_bytes = 7'h30;
            default: ctb_size_bytes = 7'h40;
        endcase
    endfunction

    function automatic logic [5:0] ctb_clip(input logic [5:0] n);
        ctb_clip = (n > MAX_BUF) ? MAX_BUF : n;
    endfunction
endpackage

/* ctb_scan.sv */
`timescale 1ns/1ns
module ctb_scan #(
    parameter int ID_W = 29
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic [31:0] mask,
    input wire logic [ID_W-1:0] probe_id,
    output logic [4:0] probe_index,
    output logic busy,
    output logic done,
    output logic found,
    output logic [4:0] best_index
);
    typedef struct packed {
        logic busy;
        logic done;
        logic found;
        logic [4:0] idx;
        logic [4:0] best;
        logic [ID_W-1:0] best_id;
        logic [31:0] snap;
    } ctb_scan_t;

    ctb_scan_t s;
    ctb_scan_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (start && !s.busy)
        begin
            next_s.busy = 1'b1;
            next_s.found = 1'b0;
            next_s.idx = 5'h00;
            next_s.snap = mask; // Later bits not seen [R21]
        end
        else if (s.busy)
        begin
            // Lowest identifier wins, ties go to lowest buffer [R16]
            if (s.snap[s.idx] && (!s.found || probe_id < s.best_id))
            begin
                next_s.found = 1'b1;
                next_s.best = s.idx;
                next_s.best_id = probe_id;
            end
            next_s.idx = s.idx + 5'h01;
            if (s.idx == 5'h1F)
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    assign probe_index = s.idx;
    assign busy = s.busy;
    assign done = s.done;
    assign found = s.found;
    assign best_index = s.best;
endmodule

/* ctb_top.sv */
`timescale 1ns/1ns
module ctb_top #(
    parameter int ID_W = 29
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] add_request,
    input wire logic [31:0] cancel_request,
    input wire logic [ID_W-1:0] probe_id,
    output logic [4:0] probe_index,
    output logic tx_select_valid,
    output logic [4:0] tx_select_index,
    input wire logic tx_start,
    input wire logic tx_done_ok,
    input wire logic tx_done_fail,
    output logic [31:0] transmission_occurred,
    output logic [31:0] cancellation_finished,
    output logic [15:0] tx_section_start,
    input wire logic [6:0] tx_byte_index,
    input wire logic [7:0] tx_ram_byte,
    output logic [7:0] tx_bus_byte,
    input wire logic [1:0] rx_target,
    input wire logic [6:0] rx_frame_bytes,
    output logic [6:0] rx_store_bytes
);
    typedef struct packed {
        logic queue_mode;
        logic [5:0] fqs;
        logic [5:0] ded_cnt;
        logic [13:0] start;
        logic [2:0] tx_ds;
        logic [2:0] rx0_size;
        logic [2:0] rx1_size;
        logic [2:0] rbds;
        logic retx_off;
        logic [31:0] pending;
        logic [31:0] cancel_req;
        logic [31:0] occurred;
        logic [31:0] cancel_fin;
        logic scan_go;
        logic rescan;
        logic active;
        logic [4:0] active_idx;
        logic sel_valid;
        logic [4:0] sel_idx;
        logic [4:0] put_rel;
        logic [4:0] get_rel;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [7:0] bus_byte;
        logic [6:0] store_bytes;
        logic [15:0] start_out;
    } ctb_state_t;

    ctb_state_t r;
    ctb_state_t next_r;

    logic sc_busy;
    logic sc_done;
    logic sc_found;
    logic [4:0] sc_best;
    logic [4:0] sc_probe;

    ctb_scan #(
        .ID_W(ID_W)
    ) u_scan (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(r.scan_go),
        .mask(r.pending),
        .probe_id(probe_id),
        .probe_index(sc_probe),
        .busy(sc_busy),
        .done(sc_done),
        .found(sc_found),
        .best_index(sc_best)
    );

    logic [5:0] nd_eff;
    logic [5:0] fq_eff;
    logic [6:0] total;
    logic [31:0] configured;
    logic [31:0] group;
    logic [5:0] fill;
    logic [5:0] free_lvl;
    logic [4:0] put_abs;
    logic [4:0] get_abs;
    logic [4:0] q_put;
    logic q_full;
    logic [31:0] status;
    logic [31:0] add_eff;
    logic [31:0] clr;
    logic [31:0] rd_mux;
    logic wr_acc;
    logic hit;

    always_comb
    begin
        nd_eff = ctb_pkg::ctb_clip(r.ded_cnt); // [R5]
        fq_eff = ctb_pkg::ctb_clip(r.fqs); // [R4]
        total = {1'b0, nd_eff} + {1'b0, fq_eff};
        configured = '0;
        group = '0;
        fill = '0;
        q_put = '0;
        q_full = 1'b1;
        // Dedicated first; a sum over 32 simply loses the top of the group [R7]
        for (int i = 31; i >= 0; i--)
        begin
            if (7'(i) < total)
                configured[i] = 1'b1;
            if (6'(i) >= nd_eff && 7'(i) < total)
            begin
                group[i] = 1'b1;
                if (!r.pending[i])
                begin
                    q_put = 5'(i);
                    q_full = 1'b0;
                end
            end
        end
        for (int i = 0; i < 32; i++)
            fill = fill + {5'h00, group[i] & r.pending[i]}; // [R8]
        free_lvl = fq_eff - fill;
        put_abs = 5'(nd_eff + {1'b0, r.put_rel}); // [R12]
        get_abs = 5'(nd_eff + {1'b0, r.get_rel});
    end

    always_comb
    begin
        status = '0;
        if (r.queue_mode)
        begin
            // Queue: first free queue buffer, no get index or free level [R10] [R11]
            status[ctb_pkg::FULL_POS] = q_full && (fq_eff != 6'h00); // [R9]
            status[ctb_pkg::PUT_LSB +: 5] = q_full ? 5'h00 : q_put;
        end
        else
        begin
            status[ctb_pkg::FULL_POS] = (free_lvl == 6'h00) && (fq_eff != 6'h00); // [R9]
            status[ctb_pkg::PUT_LSB +: 5] = put_abs; // [R12]
            status[ctb_pkg::GET_LSB +: 5] = get_abs; // [R10]
            status[ctb_pkg::FREE_LSB +: 6] = free_lvl; // [R11]
        end
    end

    always_comb
    begin
        hit = 1'b1;
        rd_mux = ctb_pkg::RESET_VAL;
        case (paddr)
            ctb_pkg::OFS_RX_ESC:
            begin
                rd_mux[ctb_pkg::RX0_SIZE_LSB +: 3] = r.rx0_size;
                rd_mux[ctb_pkg::RX1_SIZE_LSB +: 3] = r.rx1_size;
                rd_mux[ctb_pkg::RBDS_LSB +: 3] = r.rbds;
            end
            ctb_pkg::OFS_TX_CFG:
            begin
                rd_mux[ctb_pkg::QSEL_POS] = r.queue_mode;
                rd_mux[ctb_pkg::FQS_LSB +: 6] = r.fqs;
                rd_mux[ctb_pkg::DED_LSB +: 6] = r.ded_cnt;
                rd_mux[ctb_pkg::START_LSB +: 14] = r.start;
            end
            ctb_pkg::OFS_TX_STAT: rd_mux = status;
            ctb_pkg::OFS_TX_ESC: rd_mux[ctb_pkg::TXDS_LSB +: 3] = r.tx_ds;
            ctb_pkg::OFS_TX_PEND: rd_mux = r.pending;
            ctb_pkg::OFS_CTRL: rd_mux[ctb_pkg::RETX_OFF_POS] = r.retx_off;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_r = r;
        wr_acc = psel && penable && r.ready && pwrite && !r.err;
        // One wait-free access cycle; read data is latched at setup, write data at access
        next_r.ready = psel && !penable;
        // Error flag lives only beside pready
        next_r.err = 1'b0;
        if (psel && !penable)
        begin
            next_r.rdata = pwrite ? 32'h0000_0000 : rd_mux;
            next_r.err = !hit || (paddr[1:0] != 2'h0);
        end
        if (wr_acc)
        begin
            case (paddr)
                ctb_pkg::OFS_RX_ESC:
                begin
                    next_r.rx0_size = pwdata[ctb_pkg::RX0_SIZE_LSB +: 3];
                    next_r.rx1_size = pwdata[ctb_pkg::RX1_SIZE_LSB +: 3];
                    next_r.rbds = pwdata[ctb_pkg::RBDS_LSB +: 3];
                end
                ctb_pkg::OFS_TX_CFG:
                begin
                    next_r.queue_mode = pwdata[ctb_pkg::QSEL_POS]; // [R3]
                    next_r.fqs = pwdata[ctb_pkg::FQS_LSB +: 6];
                    next_r.ded_cnt = pwdata[ctb_pkg::DED_LSB +: 6];
                    next_r.start = pwdata[ctb_pkg::START_LSB +: 14];
                    next_r.put_rel = 5'h00;
                    next_r.get_rel = 5'h00;
                end
                ctb_pkg::OFS_TX_ESC: next_r.tx_ds = pwdata[ctb_pkg::TXDS_LSB +: 3];
                ctb_pkg::OFS_CTRL: next_r.retx_off = pwdata[ctb_pkg::RETX_OFF_POS];
                default: next_r.err = r.err;
            endcase
        end

        // Clears first, sets after, so a same-cycle event survives
        add_eff = add_request & configured & ~r.pending; // [R15] [R22]
        next_r.occurred = r.occurred & ~add_eff; // [R23]
        next_r.cancel_fin = r.cancel_fin & ~add_eff;
        next_r.cancel_req = r.cancel_req | (cancel_request & configured);
        clr = '0;
        for (int i = 0; i < 32; i++)
        begin
            if (next_r.cancel_req[i])
            begin
                if (!r.pending[i])
                    next_r.cancel_fin[i] = 1'b1; // [R19]
                else if (!(r.active && r.active_idx == 5'(i)))
                begin
                    // Not on the bus yet, nothing to wait for
                    clr[i] = 1'b1; // [R17] [R21]
                    next_r.cancel_fin[i] = 1'b1; // [R19]
                end
            end
        end
        next_r.scan_go = 1'b0;
        if (r.active && (tx_done_ok || tx_done_fail))
        begin
            next_r.active = 1'b0;
            if (tx_done_ok)
            begin
                clr[r.active_idx] = 1'b1;
                next_r.occurred[r.active_idx] = 1'b1; // [R23]
                if (next_r.cancel_req[r.active_idx])
                    next_r.cancel_fin[r.active_idx] = 1'b1; // [R19]
            end
            else if (next_r.cancel_req[r.active_idx] || r.retx_off)
            begin
                // Lost arbitration or error ends a cancelled or one-shot send [R19] [R20]
                clr[r.active_idx] = 1'b1;
                next_r.cancel_fin[r.active_idx] = 1'b1;
            end
            // Any end of frame needs a fresh winner [R16]
            next_r.rescan = 1'b1;
        end
        else if (tx_start && r.sel_valid && !r.active && !clr[r.sel_idx])
        begin
            next_r.active = 1'b1;
            next_r.active_idx = r.sel_idx;
            next_r.sel_valid = 1'b0;
        end
        next_r.pending = (r.pending & ~clr) | add_eff; // [R15]
        next_r.cancel_req = next_r.cancel_req & ~clr & next_r.pending; // [R18]
        if (r.sel_valid && clr[r.sel_idx])
        begin
            next_r.sel_valid = 1'b0;
            next_r.rescan = 1'b1;
        end

        // FIFO pointers follow the pending bits of the group
        if (!r.queue_mode && fq_eff != 6'h00)
        begin
            if (add_eff[put_abs])
                next_r.put_rel = (6'(r.put_rel) + 6'h01 == fq_eff) ? 5'h00 : r.put_rel + 5'h01;
            if (clr[get_abs] && fill != 6'h00)
                next_r.get_rel = (6'(r.get_rel) + 6'h01 == fq_eff) ? 5'h00 : r.get_rel + 5'h01;
        end

        // Late additions wait for the running scan to end
        if (add_eff != 32'h0000_0000 || next_r.rescan)
        begin
            if (sc_busy || r.scan_go || sc_done)
                next_r.rescan = 1'b1; // [R24]
            else
            begin
                next_r.scan_go = 1'b1; // [R16]
                next_r.rescan = 1'b0;
            end
        end
        if (sc_done)
        begin
            // A frame started this cycle must not be offered again
            next_r.sel_valid = sc_found && next_r.pending[sc_best] && !next_r.active;
            next_r.sel_idx = sc_best;
        end
        // An add in the done cycle keeps its rescan
        if (sc_done && next_r.rescan && next_r.pending != 32'h0000_0000)
        begin
            next_r.scan_go = 1'b1; // [R24]
            next_r.rescan = 1'b0;
        end
        else if (sc_done)
            next_r.rescan = 1'b0;

        // Payload sizing for both directions
        next_r.bus_byte = (tx_byte_index < ctb_pkg::ctb_size_bytes(r.tx_ds)) ? tx_ram_byte
                          : ctb_pkg::PAD_BYTE; // [R13] [R14]
        case (rx_target)
            2'h0: next_r.store_bytes = ctb_pkg::ctb_size_bytes(r.rx0_size); // [R1]
            2'h1: next_r.store_bytes = ctb_pkg::ctb_size_bytes(r.rx1_size); // [R1]
            default: next_r.store_bytes = ctb_pkg::ctb_size_bytes(r.rbds);
        endcase
        if (rx_frame_bytes < next_r.store_bytes)
            next_r.store_bytes = rx_frame_bytes; // [R2]
        // Follows the write edge, no extra cycle of stale address
        next_r.start_out = {next_r.start, 2'h0}; // [R6]
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.err;
    assign tx_select_valid = r.sel_valid;
    assign tx_select_index = r.sel_idx;
    assign transmission_occurred = r.occurred;
    assign cancellation_finished = r.cancel_fin;
    assign tx_section_start = r.start_out;
    assign tx_bus_byte = r.bus_byte;
    assign rx_store_bytes = r.store_bytes;
    assign probe_index = sc_probe;
endmodule

/* ctb_checker.sv */
`timescale 1ns/1ns
module ctb_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_select_valid,
    input wire logic [4:0] tx_select_index,
    input wire logic tx_start,
    input wire logic tx_done_ok,
    input wire logic tx_done_fail,
    input wire logic [31:0] transmission_occurred,
    input wire logic [15:0] tx_section_start,
    input wire logic [6:0] tx_byte_index,
    input wire logic [7:0] tx_ram_byte,
    input wire logic [7:0] tx_bus_byte,
    input wire logic [1:0] rx_target,
    input wire logic [6:0] rx_frame_bytes,
    input wire logic [6:0] rx_store_bytes
);
    logic [2:0] tsz;
    logic [10:0] rxc;
    logic [6:0] rx_exp;
    logic busy;
    logic [4:0] act;
    logic wr_hit;
    logic [2:0] rcode;
    logic [6:0] rcap;

    function automatic logic [6:0] sz(input logic [2:0] c);
        sz = (c < 3'h5) ? 7'h08 + {2'h0, c, 2'h0} : (c == 3'h5) ? 7'h20 : (c == 3'h6) ? 7'h30 : 7'h40;
    endfunction

    assign wr_hit = psel & penable & pready & pwrite & ~pslverr;
    assign rcode = (rx_target == 2'h0) ? rxc[2:0] : (rx_target == 2'h1) ? rxc[6:4] : rxc[10:8];
    assign rcap = sz(rcode);

    // Shadow config follows the same write edge as the design
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tsz <= 3'h0;
            rxc <= 11'h000;
            rx_exp <= 7'h00;
            busy <= 1'b0;
            act <= 5'h00;
        end
        else
        begin
            if (wr_hit && paddr == ctb_pkg::OFS_TX_ESC)
                tsz <= pwdata[2:0];
            if (wr_hit && paddr == ctb_pkg::OFS_RX_ESC)
                rxc <= pwdata[10:0];
            rx_exp <= (rx_frame_bytes < rcap) ? rx_frame_bytes : rcap;
            if (tx_start && tx_select_valid)
                busy <= 1'b1;
            else if (tx_done_ok || tx_done_fail)
                busy <= 1'b0;
            if (tx_start && tx_select_valid)
                act <= tx_select_index;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    chk_pad_fill: assert property (tx_byte_index >= sz(tsz)
        |=> tx_bus_byte == ctb_pkg::PAD_BYTE) else $error("missing byte not padded");
    chk_pad_pass: assert property (tx_byte_index < sz(tsz)
        |=> tx_bus_byte == $past(tx_ram_byte)) else $error("stored byte not passed");
    chk_rx_trunc: assert property (rx_store_bytes == rx_exp)
        else $error("receive byte count wrong");
    chk_section_map: assert property (wr_hit && paddr == ctb_pkg::OFS_TX_CFG
        |=> tx_section_start == {$past(pwdata[15:2]), 2'h0}) else $error("section start wrong");
    chk_start_drop: assert property (tx_start && tx_select_valid |=> !tx_select_valid)
        else $error("selection kept after start");
    chk_ok_occurred: assert property (tx_done_ok && busy |-> ##[1:2] transmission_occurred[act])
        else $error("occurred bit not set");

    cover property (tx_done_ok);
    cover property (tx_done_fail);
    cover property (pslverr);
endmodule

/* ctb_can_engine.sv */
`timescale 1ns/1ns
module ctb_can_engine (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [4:0] probe_index,
    input wire logic tx_select_valid,
    input wire logic go,
    input wire logic fail,
    input wire logic [7:0] dly,
    output logic [28:0] probe_id,
    output logic tx_start,
    output logic tx_done_ok,
    output logic tx_done_fail
);
    logic [7:0] cnt;

    // Higher buffer number gets the lower id, so priority is not index order
    assign probe_id = {24'h000010, ~probe_index};

    always_ff @(posedge clk_sys)
    begin
        tx_start <= 1'b0;
        tx_done_ok <= 1'b0;
        tx_done_fail <= 1'b0;
        if (reset)
            cnt <= 8'h00;
        else if (cnt == 8'h00 && go && tx_select_valid)
        begin
            tx_start <= 1'b1;
            cnt <= dly;
        end
        else if (cnt == 8'h01)
        begin
            tx_done_ok <= !fail;
            tx_done_fail <= fail;
            cnt <= 8'h00;
        end
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, fail = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, add_request = 32'h0, cancel_request = 32'h0;
    logic [28:0] probe_id;
    logic [4:0] probe_index, tx_select_index;
    logic tx_select_valid, tx_start, tx_done_ok, tx_done_fail, pready, pslverr, rerr;
    logic [31:0] prdata, transmission_occurred, cancellation_finished, rdat;
    logic [15:0] tx_section_start;
    logic [6:0] tx_byte_index = 7'h00, rx_frame_bytes = 7'h00, rx_store_bytes;
    logic [7:0] tx_ram_byte = 8'h5A, tx_bus_byte, dly = 8'h01;
    logic [1:0] rx_target = 2'h0;
    int errors = 0, compares = 0;

    always #10 clk_sys = ~clk_sys;

    ctb_top i_ctb_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .add_request, .cancel_request, .probe_id, .probe_index, .tx_select_valid, .tx_select_index,
        .tx_start, .tx_done_ok, .tx_done_fail, .transmission_occurred, .cancellation_finished,
        .tx_section_start, .tx_byte_index, .tx_ram_byte, .tx_bus_byte, .rx_target, .rx_frame_bytes,
        .rx_store_bytes);
    ctb_can_engine i_ctb_can_engine (.clk_sys, .reset, .probe_index, .tx_select_valid, .go, .fail, .dly,
        .probe_id, .tx_start, .tx_done_ok, .tx_done_fail);

    task conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bounded wait for every handshake: 0 select, 1 start, 2 done, 3 pready
    task wt(input int k);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (n < 300 && !(k == 0 ? tx_select_valid === 1'b1 : k == 1 ? tx_start === 1'b1 :
            k == 2 ? (tx_done_ok | tx_done_fail) === 1'b1 : pready === 1'b1));
        if (n >= 300)
        begin
            errors++;
            conclude;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        wt(3);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rdat);
        chk("slave error", {31'h0, ee}, {31'h0, rerr});
    endtask

    task req(input logic c, input logic [31:0] b);
        @(posedge clk_sys);
        if (c)
            cancel_request <= b;
        else
            add_request <= b;
        @(posedge clk_sys);
        add_request <= 32'h0;
        cancel_request <= 32'h0;
        repeat (2) @(posedge clk_sys);
    endtask

    task run(input logic f, input logic [7:0] d);
        @(posedge clk_sys);
        go <= 1'b1;
        fail <= f;
        dly <= d;
        wt(1);
        go <= 1'b0;
    endtask

    function automatic logic [6:0] sz(input logic [2:0] c);
        sz = (c < 3'h5) ? 7'h08 + {2'h0, c, 2'h0} : (c == 3'h5) ? 7'h20 : (c == 3'h6) ? 7'h30 : 7'h40;
    endfunction

    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(ctb_pkg::OFS_TX_CFG, 32'h0, 1'b0);
        rd(ctb_pkg::OFS_TX_STAT, 32'h0, 1'b0);
        rd(ctb_pkg::OFS_TX_PEND, 32'h0, 1'b0);
        rd(12'h0FC, 32'h0, 1'b1);
        rd(12'h0C1, 32'h0, 1'b1);
        $display("register test done");
        apb(1'b1, ctb_pkg::OFS_TX_CFG, 32'h003F_0000);
        req(1'b0, 32'h8000_0000);
        rd(ctb_pkg::OFS_TX_PEND, 32'h8000_0000, 1'b0);
        req(1'b1, 32'h8000_0000);
        chk("finished", 32'h8000_0000, cancellation_finished);
        rd(ctb_pkg::OFS_TX_PEND, 32'h0, 1'b0);
        apb(1'b1, ctb_pkg::OFS_TX_CFG, 32'h4402_0040);
        rd(ctb_pkg::OFS_TX_CFG, 32'h4402_0040, 1'b0);
        chk("section start", 32'h40, {16'h0, tx_section_start});
        rd(ctb_pkg::OFS_TX_STAT, 32'h0002_0000, 1'b0);
        req(1'b0, 32'h0000_0040);
        req(1'b0, 32'h0000_0014);
        rd(ctb_pkg::OFS_TX_PEND, 32'h14, 1'b0);
        rd(ctb_pkg::OFS_TX_STAT, 32'h0003_0000, 1'b0);
        $display("config test done");
        wt(0);
        chk("select", 32'h4, {27'h0, tx_select_index});
        run(1'b0, 8'h03);
        wt(2);
        repeat (2) @(posedge clk_sys);
        chk("occurred", 32'h10, transmission_occurred);
        rd(ctb_pkg::OFS_TX_PEND, 32'h04, 1'b0);
        wt(0);
        chk("select", 32'h2, {27'h0, tx_select_index});
        run(1'b1, 8'h14);
        req(1'b1, 32'h04);
        rd(ctb_pkg::OFS_TX_PEND, 32'h04, 1'b0);
        wt(2);
        repeat (2) @(posedge clk_sys);
        chk("finished", 32'h8000_0004, cancellation_finished);
        rd(ctb_pkg::OFS_TX_PEND, 32'h0, 1'b0);
        apb(1'b1, ctb_pkg::OFS_CTRL, 32'h1);
        req(1'b0, 32'h02);
        wt(0);
        run(1'b1, 8'h02);
        wt(2);
        repeat (2) @(posedge clk_sys);
        chk("finished", 32'h8000_0006, cancellation_finished);
        rd(ctb_pkg::OFS_TX_PEND, 32'h0, 1'b0);
        req(1'b0, 32'h10);
        chk("occurred", 32'h0, transmission_occurred);
        req(1'b1, 32'h01);
        chk("finished", 32'h8000_0007, cancellation_finished);
        req(1'b0, 32'h2C);
        apb(1'b0, ctb_pkg::OFS_TX_STAT, 32'h0);
        chk("full", 32'h1, {31'h0, rdat[21]});
        apb(1'b1, ctb_pkg::OFS_TX_CFG, 32'h0402_0000);
        rd(ctb_pkg::OFS_TX_STAT, 32'h0022_0200, 1'b0);
        req(1'b1, 32'h04);
        rd(ctb_pkg::OFS_TX_STAT, 32'h0002_0301, 1'b0);
        $display("transmit test done");
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, ctb_pkg::OFS_TX_ESC, {29'h0, 3'(c)});
            tx_byte_index <= sz(3'(c)) - 7'h01;
            repeat (2) @(posedge clk_sys);
            chk("bus byte", 32'h5A, {24'h0, tx_bus_byte});
            tx_byte_index <= sz(3'(c));
            repeat (2) @(posedge clk_sys);
            chk("pad byte", 32'hCC, {24'h0, tx_bus_byte});
        end
        rx_frame_bytes <= 7'h40;
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, ctb_pkg::OFS_RX_ESC, {21'h0, 3'(c), 1'b0, 3'(7 - c), 1'b0, 3'(c)});
            for (int t = 0; t < 3; t++)
            begin
                rx_target <= 2'(t);
                repeat (2) @(posedge clk_sys);
                chk("stored", {25'h0, sz(t == 1 ? 3'(7 - c) : 3'(c))}, {25'h0, rx_store_bytes});
            end
        end
        rx_frame_bytes <= 7'h05;
        repeat (2) @(posedge clk_sys);
        chk("stored", 32'h5, {25'h0, rx_store_bytes});
        $display("size test done");
        conclude;
    end
endmodule

bind ctb_top ctb_checker i_ctb_checker (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .tx_select_valid, .tx_select_index, .tx_start, .tx_done_ok, .tx_done_fail,
    .transmission_occurred, .tx_section_start, .tx_byte_index, .tx_ram_byte, .tx_bus_byte, .rx_target,
    .rx_frame_bytes, .rx_store_bytes);
